/* File: dv/test_mcu_clock_generation_control.sv */
`timescale 1ns/1ns
`default_nettype none

module test_mcu_clock_generation_control
   import clock_gen_pkg::*;
;
   typedef struct {
      logic [7:0] c0, c1, sd, fc;
      logic [3:0] md;
      logic       mo, fm;
      int         e [5];
   } row_t;

   logic          clk, rst, softReset, regWrite, clockWriteGuard, voltageWriteGuard;
   logic          waitMode, stopMode, wdtProtectMode, extClockMode;
   logic          mainClockTick, fastOscTick, slowOscTick;
   reg_select_t   regSelect;
   logic [7:0]    regWriteData;
   clock_cfg_t    cfg;
   clock_pulses_t clocks;
   logic          mainOscEnable, feedbackResistorOn, mainStopped;
   logic          sysclkFromMain, monitor1Ready, monitor2Ready;
   logic          run, mainOn, ph, clr;
   logic [1:0]    q;
   int            cnt [11];
   int            miscompares, n_checks;
   string         nm [11] = '{"cpu", "f1", "f2", "f4", "f8", "f32", "onchipOsc", "fastTimer",
                              "converterFast", "slowSafety", "onchipDiv128"};
   // Registers c0 c1 sd fc, modes wait/stop/wdt/ext, main ticks, from main; cpu f1 oco safe fast
   row_t          rows [15] = '{
      '{8'h60, 8'h00, 8'h04, 8'h00, 4'h0, 1'b0, 1'b0, '{32, 256, 256, 256, 0}},
      '{8'h20, 8'h40, 8'h04, 8'h00, 4'h0, 1'b0, 1'b0, '{128, 256, 256, 256, 0}},
      '{8'h20, 8'h80, 8'h04, 8'h00, 4'h0, 1'b0, 1'b0, '{64, 256, 256, 256, 0}},
      '{8'h20, 8'hc0, 8'h04, 8'h00, 4'h0, 1'b0, 1'b0, '{16, 256, 256, 256, 0}},
      '{8'h60, 8'hc0, 8'h04, 8'h00, 4'h0, 1'b0, 1'b0, '{32, 256, 256, 256, 0}},
      '{8'h20, 8'h00, 8'h04, 8'h00, 4'h0, 1'b0, 1'b0, '{256, 256, 256, 256, 0}},
      '{8'h20, 8'h00, 8'h04, 8'h01, 4'h0, 1'b0, 1'b0, '{256, 256, 256, 256, 512}},
      '{8'h20, 8'h00, 8'h04, 8'h03, 4'h0, 1'b0, 1'b0, '{512, 512, 512, 256, 512}},
      '{8'h20, 8'h00, 8'h04, 8'h03, 4'h8, 1'b0, 1'b0, '{0, 512, 512, 256, 512}},
      '{8'h24, 8'h00, 8'h04, 8'h03, 4'h8, 1'b0, 1'b0, '{0, 0, 512, 256, 512}},
      '{8'h00, 8'h08, 8'h04, 8'h03, 4'h4, 1'b1, 1'b0, '{0, 0, 0, 0, 0}},
      '{8'h00, 8'h08, 8'h04, 8'h03, 4'h6, 1'b1, 1'b0, '{0, 0, 0, 256, 0}},
      '{8'h00, 8'h08, 8'h00, 8'h03, 4'h0, 1'b1, 1'b1, '{128, 128, 512, -1, 512}},
      '{8'h20, 8'h08, 8'h00, 8'h03, 4'h1, 1'b1, 1'b1, '{128, 128, 512, -1, 512}},
      '{8'h00, 8'h08, 8'h03, 8'h03, 4'h0, 1'b0, 1'b0, '{512, 512, 512, 256, 512}}};

   clock_gen_control #(.MONITOR_START_CYCLES(20)) u_dut (
      .clk(clk), .rst(rst), .softReset(softReset), .regWrite(regWrite), .regSelect(regSelect),
      .regWriteData(regWriteData), .clockWriteGuard(clockWriteGuard), .voltageWriteGuard(voltageWriteGuard),
      .waitMode(waitMode), .stopMode(stopMode), .wdtProtectMode(wdtProtectMode), .extClockMode(extClockMode),
      .mainClockTick(mainClockTick), .fastOscTick(fastOscTick), .slowOscTick(slowOscTick), .cfg(cfg),
      .clocks(clocks), .mainOscEnable(mainOscEnable), .feedbackResistorOn(feedbackResistorOn),
      .mainStopped(mainStopped), .sysclkFromMain(sysclkFromMain), .monitor1Ready(monitor1Ready),
      .monitor2Ready(monitor2Ready));

   ////////////////////////////////////////////////////////////////////////////////
   always #5 clk = ~clk;

   // Fast every cycle, slow every second, main every fourth
   always @(posedge clk) begin
      ph <= ~ph;
      q <= q + 2'h1;
      slowOscTick <= run & ph;
      fastOscTick <= run;
      mainClockTick <= run & mainOn & (q == 2'h0);
   end

   always @(posedge clk) begin
      for (int j = 0; j < 11; j++) begin
         cnt[j] <= clr ? 0 : cnt[j] + ((clocks[10-j] === 1'b1) ? 1 : 0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // Guard bits: [1] clock group, [0] voltage register
   task automatic wr(input reg_select_t s, input logic [7:0] d, input logic [1:0] g);
      @(posedge clk);
      regSelect <= s;
      regWriteData <= d;
      {clockWriteGuard, voltageWriteGuard} <= g;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      {clockWriteGuard, voltageWriteGuard} <= 2'h0;
      @(negedge clk);
   endtask

   // Warm-up realigns prescalers, then counts pulses over 512 cycles
   task automatic do_row(input int i, input row_t r);
      int e [11];
      int tol;
      e = '{r.e[0], r.e[1], r.e[1] / 2, r.e[1] / 4, r.e[1] / 8, r.e[1] / 32, r.e[2], r.e[4], r.e[4], r.e[3],
            r.e[2] / 128};
      // Leave every mode so that each row enters its own mode afresh
      @(posedge clk);
      {waitMode, stopMode, wdtProtectMode, extClockMode} <= 4'h0;
      wr(SEL_CLOCK1, r.c1, 2'h2);
      wr(SEL_CLOCK0, r.c0, 2'h2);
      wr(SEL_STOP_DETECT, r.sd, 2'h2);
      wr(SEL_FAST_CTRL, r.fc, 2'h2);
      @(posedge clk);
      {waitMode, stopMode, wdtProtectMode, extClockMode} <= r.md;
      mainOn <= r.mo;
      run <= 1'b1;
      repeat (256) @(posedge clk);
      run <= 1'b0;
      repeat (4) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      run <= 1'b1;
      repeat (512) @(posedge clk);
      run <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      for (int j = 0; j < 11; j++) begin
         tol = (e[j] > 0) ? 1 : 0;
         if (e[j] >= 0) begin
            n_checks++;
            if (cnt[j] > e[j] + tol || cnt[j] + tol < e[j]) begin
               miscompares++;
               $display("mismatch %s expected %0d seen %0d", nm[j], e[j], cnt[j]);
            end
         end
      end
      chk("mainOscEnable", {31'h0, r.c1[3] & ~r.c0[5] & ~r.md[2]}, {31'h0, mainOscEnable});
      chk("sysclkFromMain", {31'h0, r.fm}, {31'h0, sysclkFromMain});
      chk("sysclkSourceSelect", {31'h0, ~r.fm}, {31'h0, cfg.sysclkSourceSelect});
      chk("mainStopped", {31'h0, r.sd[1:0] == 2'h3 && !r.mo}, {31'h0, mainStopped});
      chk("feedbackResistorOn", {31'h0, r.c1[3] & ~r.md[2]}, {31'h0, feedbackResistorOn});
      if (r.md[2]) begin
         chk("div8Select", 32'h1, {31'h0, cfg.div8Select});
      end
      $display("test row %0d done", i);
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      softReset = 1'b0;
      regWrite = 1'b0;
      regSelect = SEL_CLOCK0;
      regWriteData = 8'h00;
      {clockWriteGuard, voltageWriteGuard} = 2'h0;
      {waitMode, stopMode, wdtProtectMode, extClockMode} = 4'h0;
      {mainClockTick, fastOscTick, slowOscTick} = 3'h0;
      {run, mainOn, ph, clr} = 4'h1;
      q = 2'h0;
      miscompares = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      clr <= 1'b0;
      @(negedge clk);
      chk("mainOscStop", 32'h1, {31'h0, cfg.mainOscStop});
      chk("div8Select", 32'h1, {31'h0, cfg.div8Select});
      chk("sysclkSourceSelect", 32'h1, {31'h0, cfg.sysclkSourceSelect});
      chk("oscSelect", 32'h0, {31'h0, cfg.oscSelect});
      chk("fastOscOn", 32'h0, {31'h0, cfg.fastOscOn});
      chk("mainOscEnable", 32'h0, {31'h0, mainOscEnable});
      chk("sysclkFromMain", 32'h0, {31'h0, sysclkFromMain});
      $display("test reset done");
      wr(SEL_FAST_TRIM, 8'h33, 2'h1);
      chk("fastOscTrim", 32'h80, {24'h0, cfg.fastOscTrim});
      wr(SEL_FAST_TRIM, 8'h5a, 2'h2);
      chk("fastOscTrim", 32'h5a, {24'h0, cfg.fastOscTrim});
      wr(SEL_FAST_DIVIDE, 8'h02, 2'h2);
      chk("fastOscDivide", 32'h2, {29'h0, cfg.fastOscDivide});
      wr(SEL_VOLTAGE2, 8'hc0, 2'h2);
      chk("monitor2Enable", 32'h0, {31'h0, cfg.monitor2Enable});
      wr(SEL_VOLTAGE2, 8'hc0, 2'h1);
      repeat (19) @(posedge clk);
      @(negedge clk);
      chk("monitorReady", 32'h0, {30'h0, monitor1Ready, monitor2Ready});
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("monitorReady", 32'h3, {30'h0, monitor1Ready, monitor2Ready});
      @(posedge clk);
      softReset <= 1'b1;
      @(posedge clk);
      softReset <= 1'b0;
      @(negedge clk);
      chk("monitor2Enable", 32'h1, {31'h0, cfg.monitor2Enable});
      chk("monitor1Enable", 32'h0, {31'h0, cfg.monitor1Enable});
      chk("fastOscTrim", 32'h80, {24'h0, cfg.fastOscTrim});
      $display("test guards and monitors done");
      for (int i = 0; i < 15; i++) begin
         do_row(i, rows[i]);
      end
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("monitor2Enable", 32'h0, {31'h0, cfg.monitor2Enable});
      chk("div8Select", 32'h1, {31'h0, cfg.div8Select});
      $display("test second reset done");
      finish_test;
   end

   initial begin
      #200000;
      miscompares++;
      $display("watchdog expired");
      finish_test;
   end

endmodule

`default_nettype wire

/* File: src/clock_gen_control.sv */
`timescale 1ns/1ns
`default_nettype none

`include "clock_gen_map.svh"

module clock_gen_control
   import clock_gen_pkg::*;
#(
   parameter int MONITOR_START_CYCLES = `MON_START_CYCLES
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          softReset,
   input  wire logic          regWrite,
   input  wire reg_select_t   regSelect,
   input  wire logic [7:0]    regWriteData,
   input  wire logic          clockWriteGuard,
   input  wire logic          voltageWriteGuard,
   input  wire logic          waitMode,
   input  wire logic          stopMode,
   input  wire logic          wdtProtectMode,
   input  wire logic          extClockMode,
   input  wire logic          mainClockTick,
   input  wire logic          fastOscTick,
   input  wire logic          slowOscTick,
   output var  clock_cfg_t    cfg,
   output var  clock_pulses_t clocks,
   output var  logic          mainOscEnable,
   output var  logic          feedbackResistorOn,
   output var  logic          mainStopped,
   output var  logic          sysclkFromMain,
   output var  logic          monitor1Ready,
   output var  logic          monitor2Ready
);

   localparam clock_cfg_t CFG_RESET = '{
      periphWaitStop:     1'b0,
      mainOscStop:        `RST_MAIN_OSC_STOP,
      div8Select:         `RST_DIV8_SELECT,
      mainPinSelect:      1'b0,
      slowOscOff:         `RST_SLOW_OSC_OFF,
      cpuDiv:             `RST_CPU_DIV,
      sysclkSourceSelect: `RST_SRC_SELECT,
      stopDetectCfg:      `RST_STOP_DETECT_CFG,
      fastOscOn:          1'b0,
      oscSelect:          1'b0,
      fastOscTrim:        `RST_FAST_TRIM,
      fastOscDivide:      `RST_FAST_DIVIDE,
      monitor1Enable:     1'b0,
      monitor2Enable:     1'b0
   };
   localparam logic [19:0] MON_LIMIT = 20'(MONITOR_START_CYCLES);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   function automatic logic [3:0] cpuMask(input logic div8, input logic [1:0] field);
      logic [3:0] m;
      m = `CPU_MASK_DIV8;
      if (!div8) begin
         unique case (field)
            2'h0: m = 4'h0;
            2'h1: m = 4'h1;
            2'h2: m = 4'h3;
            2'h3: m = 4'hf;
         endcase
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Configuration bits

   clock_cfg_t next_cfg;
   logic       stopPrev;
   logic       next_stopPrev;

   always_comb begin
      next_cfg      = cfg;
      next_stopPrev = stopMode;
      if (softReset) begin
         next_cfg                = CFG_RESET;
         next_cfg.monitor2Enable = cfg.monitor2Enable;
      end else if (regWrite) begin
         unique case (regSelect)
            SEL_CLOCK0: if (clockWriteGuard) begin
               next_cfg.periphWaitStop = regWriteData[`SC0_PERIPH_WAIT_STOP_BIT];
               next_cfg.mainOscStop    = regWriteData[`SC0_MAIN_OSC_STOP_BIT];
               next_cfg.div8Select     = regWriteData[`SC0_DIV8_SELECT_BIT];
            end
            SEL_CLOCK1: if (clockWriteGuard) begin
               // Pin select is sticky once set
               next_cfg.mainPinSelect = cfg.mainPinSelect | regWriteData[`SC1_MAIN_PIN_SELECT_BIT];
               if (!wdtProtectMode) begin
                  next_cfg.slowOscOff = regWriteData[`SC1_SLOW_OSC_OFF_BIT];
               end
               next_cfg.cpuDiv = regWriteData[`SC1_CPU_DIV_HIGH_BIT:`SC1_CPU_DIV_LOW_BIT];
            end
            SEL_STOP_DETECT: if (clockWriteGuard) begin
               next_cfg.stopDetectCfg      = regWriteData[`SD_CFG_HIGH_BIT:`SD_CFG_LOW_BIT];
               next_cfg.sysclkSourceSelect = regWriteData[`SD_SRC_SELECT_BIT];
            end
            SEL_FAST_CTRL: if (clockWriteGuard) begin
               next_cfg.fastOscOn = regWriteData[`FC_ON_BIT];
               next_cfg.oscSelect = regWriteData[`FC_OSC_SELECT_BIT];
            end
            SEL_FAST_TRIM: if (clockWriteGuard) begin
               next_cfg.fastOscTrim = regWriteData;
            end
            SEL_FAST_DIVIDE: if (clockWriteGuard) begin
               next_cfg.fastOscDivide = regWriteData[`FD_HIGH_BIT:`FD_LOW_BIT];
            end
            SEL_VOLTAGE2: if (voltageWriteGuard) begin
               next_cfg.monitor1Enable = regWriteData[`V2_MON1_ENABLE_BIT];
               next_cfg.monitor2Enable = regWriteData[`V2_MON2_ENABLE_BIT];
            end
            default: ;
         endcase
      end
      // Hardware updates win over software writes
      if (mainStopped && cfg.stopDetectCfg == 2'h3) begin
         next_cfg.sysclkSourceSelect = 1'b1;
      end
      if (next_cfg.sysclkSourceSelect) begin
         next_cfg.slowOscOff = 1'b0;
      end
      if (stopMode && !stopPrev) begin
         next_cfg.div8Select = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg      <= CFG_RESET;
         stopPrev <= 1'b0;
      end else begin
         cfg      <= next_cfg;
         stopPrev <= next_stopPrev;
      end
   end

   a_trim_guard: assert property (regWrite && regSelect == SEL_FAST_TRIM && !clockWriteGuard && !softReset
      |=> $stable(cfg.fastOscTrim)) else $error("Trim changed without guard");
   a_voltage_guard: assert property (regWrite && regSelect == SEL_VOLTAGE2 && !voltageWriteGuard
      && !softReset |=> $stable(cfg.monitor1Enable) && $stable(cfg.monitor2Enable)) else $error("No voltage guard");
   a_mon2_keep: assert property (softReset |=> $stable(cfg.monitor2Enable))
      else $error("Monitor 2 enable lost on soft reset");
   a_auto_onchip: assert property (mainStopped && cfg.stopDetectCfg == 2'h3
      |=> cfg.sysclkSourceSelect && !cfg.slowOscOff) else $error("No fallback on main stop");
   a_div8_stop: assert property ($rose(stopMode) |=> cfg.div8Select)
      else $error("Div8 not forced on stop");

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator gating and source selection

   logic     mainTick;
   logic     ocoTick;
   logic     sysTick;
   sys_src_t src;
   sys_src_t next_src;
   logic     next_mainOscEnable;
   logic     next_feedback;

   always_comb begin
      next_mainOscEnable = cfg.mainPinSelect && !cfg.mainOscStop && !stopMode;
      next_feedback      = cfg.mainPinSelect && !stopMode;
      mainTick = mainClockTick && (mainOscEnable || extClockMode) && !stopMode;
      ocoTick  = cfg.oscSelect ? (fastOscTick && cfg.fastOscOn)
                               : (slowOscTick && !cfg.slowOscOff);
      sysTick  = !stopMode && (src == SRC_MAIN ? mainTick : ocoTick);
      next_src = src;
      // Hand over only on an edge of the old source, or when it is dead
      unique case (src)
         SRC_ONCHIP: if (!cfg.sysclkSourceSelect && (ocoTick || stopMode)) next_src = SRC_MAIN;
         SRC_MAIN:   if (cfg.sysclkSourceSelect && (mainTick || mainStopped)) next_src = SRC_ONCHIP;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src                <= SRC_ONCHIP;
         mainOscEnable      <= 1'b0;
         feedbackResistorOn <= 1'b0;
         sysclkFromMain     <= 1'b0;
      end else begin
         src                <= next_src;
         mainOscEnable      <= next_mainOscEnable;
         feedbackResistorOn <= next_feedback;
         sysclkFromMain     <= next_src == SRC_MAIN;
      end
   end

   clock_stop_detector u_stop_detect (
      .clk     (clk),
      .rst     (rst),
      .enable  (cfg.stopDetectCfg[0]),
      .tick    (mainTick),
      .stopped (mainStopped)
   );

   a_crystal_off: assert property (!cfg.mainPinSelect |=> !mainOscEnable)
      else $error("Crystal enabled before pin select");

   ////////////////////////////////////////////////////////////////////////////
   // Dividers and clock enables

   logic [6:0]    sysCount;
   logic [6:0]    ocoCount;
   logic [3:0]    activeMask;
   logic [3:0]    next_activeMask;
   clock_pulses_t next_clocks;
   logic          periphRun;

   clock_prescaler #(.WIDTH(7)) u_sys_prescaler (
      .clk   (clk),
      .rst   (rst),
      .tick  (sysTick),
      .count (sysCount)
   );

   clock_prescaler #(.WIDTH(7)) u_oco_prescaler (
      .clk   (clk),
      .rst   (rst),
      .tick  (ocoTick && !stopMode),
      .count (ocoCount)
   );

   always_comb begin
      next_activeMask = activeMask;
      // New divisor applied at the common period boundary only
      if (sysTick && sysCount[3:0] == `SYS_PERIOD_END) begin
         next_activeMask = cpuMask(cfg.div8Select, cfg.cpuDiv);
      end
      periphRun = !(waitMode && cfg.periphWaitStop);
      next_clocks.cpu = sysTick && !waitMode && ((sysCount[3:0] & activeMask) == activeMask);
      next_clocks.f1  = sysTick && periphRun;
      next_clocks.f2  = sysTick && periphRun && sysCount[0];
      next_clocks.f4  = sysTick && periphRun && &sysCount[1:0];
      next_clocks.f8  = sysTick && periphRun && &sysCount[2:0];
      next_clocks.f32 = sysTick && periphRun && &sysCount[4:0];
      next_clocks.onchipOsc     = ocoTick && !stopMode;
      next_clocks.fastTimer     = fastOscTick && cfg.fastOscOn && !stopMode;
      next_clocks.converterFast = fastOscTick && cfg.fastOscOn && !stopMode;
      next_clocks.slowSafety    = slowOscTick && !cfg.slowOscOff && (!stopMode || wdtProtectMode);
      next_clocks.onchipDiv128  = ocoTick && !stopMode && ocoCount == `OCO_DIV128_END;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         activeMask <= `CPU_MASK_DIV8;
         clocks     <= '0;
      end else begin
         activeMask <= next_activeMask;
         clocks     <= next_clocks;
      end
   end

   a_stop_halts: assert property (stopMode |=> !clocks.cpu && !clocks.f1 && !clocks.onchipOsc
      && !clocks.fastTimer) else $error("Clock running in stop mode");
   a_periph_gate: assert property (waitMode && cfg.periphWaitStop |=> !clocks.f1 && !clocks.f32)
      else $error("Peripheral clock in gated wait");
   a_fast_off: assert property (!cfg.fastOscOn |=> !clocks.fastTimer && !clocks.converterFast)
      else $error("Fast clock without fast oscillator");
   a_div128_rate: assert property (clocks.onchipDiv128 |-> clocks.onchipOsc ##1 !clocks.onchipDiv128 [*8])
      else $error("Div128 pulse off its on-chip tick or too close");

   ////////////////////////////////////////////////////////////////////////////
   // Voltage monitor start delay

   logic [19:0] monCount [2];
   logic [19:0] next_monCount [2];
   logic [1:0]  monEnable;
   logic [1:0]  next_monReady;

   always_comb begin
      monEnable = {cfg.monitor2Enable, cfg.monitor1Enable};
      for (int i = 0; i < 2; i++) begin
         next_monCount[i] = monCount[i];
         if (!monEnable[i]) begin
            next_monCount[i] = '0;
         end else if (monCount[i] != MON_LIMIT) begin
            next_monCount[i] = monCount[i] + 20'h00001;
         end
         next_monReady[i] = monEnable[i] && next_monCount[i] == MON_LIMIT;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         monCount[0]   <= '0;
         monCount[1]   <= '0;
         monitor1Ready <= 1'b0;
         monitor2Ready <= 1'b0;
      end else begin
         monCount[0]   <= next_monCount[0];
         monCount[1]   <= next_monCount[1];
         monitor1Ready <= next_monReady[0];
         monitor2Ready <= next_monReady[1];
      end
   end

   a_mon1_delay: assert property ($rose(cfg.monitor1Enable) |-> !monitor1Ready [*8])
      else $error("Monitor 1 ready too early");
   a_mon2_delay: assert property ($rose(cfg.monitor2Enable) |-> !monitor2Ready [*8])
      else $error("Monitor 2 ready too early");

endmodule

`default_nettype wire

/* File: src/clock_gen_map.svh */
`ifndef CLOCK_GEN_MAP_SVH
`define CLOCK_GEN_MAP_SVH

// Clock rate
`define CLK_PERIOD_NS            10

// Timing
`define MON_START_DELAY_NS       300000
`define MON_START_CYCLES         ((`MON_START_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MAIN_STOP_TIMEOUT_NS     2000
`define MAIN_STOP_CYCLES         ((`MAIN_STOP_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// System clock control 0 fields
`define SC0_PERIPH_WAIT_STOP_BIT 2
`define SC0_MAIN_OSC_STOP_BIT    5
`define SC0_DIV8_SELECT_BIT      6

// System clock control 1 fields
`define SC1_MAIN_PIN_SELECT_BIT  3
`define SC1_SLOW_OSC_OFF_BIT     4
`define SC1_CPU_DIV_LOW_BIT      6
`define SC1_CPU_DIV_HIGH_BIT     7

// Stop detect register fields
`define SD_CFG_LOW_BIT           0
`define SD_CFG_HIGH_BIT          1
`define SD_SRC_SELECT_BIT        2

// Fast oscillator control fields
`define FC_ON_BIT                0
`define FC_OSC_SELECT_BIT        1

// Fast oscillator divide field
`define FD_LOW_BIT               0
`define FD_HIGH_BIT              2

// Voltage control 2 fields
`define V2_MON1_ENABLE_BIT       6
`define V2_MON2_ENABLE_BIT       7

// Reset values
`define RST_MAIN_OSC_STOP        1'b1
`define RST_DIV8_SELECT          1'b1
`define RST_SRC_SELECT           1'b1
`define RST_SLOW_OSC_OFF         1'b0
`define RST_CPU_DIV              2'h0
`define RST_STOP_DETECT_CFG      2'h0
`define RST_FAST_TRIM            8'h80
`define RST_FAST_DIVIDE          3'h0

// Divider mask and end counts
`define CPU_MASK_DIV8            4'h7
`define SYS_PERIOD_END           4'hf
`define OCO_DIV128_END           7'h7f

`endif

/* File: src/clock_gen_pkg.sv */
package clock_gen_pkg;

   typedef enum logic [2:0] {
      SEL_CLOCK0,
      SEL_CLOCK1,
      SEL_STOP_DETECT,
      SEL_FAST_CTRL,
      SEL_FAST_TRIM,
      SEL_FAST_DIVIDE,
      SEL_VOLTAGE2
   } reg_select_t;

   typedef enum logic {
      SRC_ONCHIP,
      SRC_MAIN
   } sys_src_t;

   typedef struct packed {
      logic       periphWaitStop;
      logic       mainOscStop;
      logic       div8Select;
      logic       mainPinSelect;
      logic       slowOscOff;
      logic [1:0] cpuDiv;
      logic       sysclkSourceSelect;
      logic [1:0] stopDetectCfg;
      logic       fastOscOn;
      logic       oscSelect;
      logic [7:0] fastOscTrim;
      logic [2:0] fastOscDivide;
      logic       monitor1Enable;
      logic       monitor2Enable;
   } clock_cfg_t;

   typedef struct packed {
      logic cpu;
      logic f1;
      logic f2;
      logic f4;
      logic f8;
      logic f32;
      logic onchipOsc;
      logic fastTimer;
      logic converterFast;
      logic slowSafety;
      logic onchipDiv128;
   } clock_pulses_t;

endpackage

/* File: src/clock_prescaler.sv */
`timescale 1ns/1ns
`default_nettype none

module clock_prescaler #(
   parameter int WIDTH = 7
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             tick,
   output var  logic [WIDTH-1:0] count
);

   logic [WIDTH-1:0] next_count;

   always_comb begin
      next_count = count;
      if (tick) begin
         next_count = count + WIDTH'(1);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

endmodule

`default_nettype wire

/* File: src/clock_stop_detector.sv */
`timescale 1ns/1ns
`default_nettype none

`include "clock_gen_map.svh"

module clock_stop_detector (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic tick,
   output var  logic stopped
);

   localparam logic [15:0] LIMIT = 16'(`MAIN_STOP_CYCLES);

   logic [15:0] idle;
   logic [15:0] next_idle;
   logic        next_stopped;

   // Stopped once no edge for the whole timeout; cleared by a new edge
   always_comb begin
      next_idle    = idle;
      next_stopped = stopped;
      if (!enable || tick) begin
         next_idle    = '0;
         next_stopped = 1'b0;
      end else if (idle != LIMIT) begin
         next_idle = idle + 16'h0001;
      end else begin
         next_stopped = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idle    <= '0;
         stopped <= 1'b0;
      end else begin
         idle    <= next_idle;
         stopped <= next_stopped;
      end
   end

endmodule

`default_nettype wire
